//--- rpes_pkg.sv
// Shared constants for the radio power enable sequencer
package rpes_pkg;
    // Clock is 25 MHz; one millisecond is this many cycles
    localparam int unsigned CLK_HZ          = 25000000;
    localparam int unsigned MS_CYCLES       = (CLK_HZ + 999) / 1000;
    // Minimum host delays, in milliseconds
    localparam int unsigned OFF_GAP_MS      = 10;
    localparam int unsigned ACCESS_WAIT_MS  = 150;
    localparam int unsigned RADIO_HOLD_MS   = 100;
    // Longest power-on reset hold of the device, in milliseconds
    localparam int unsigned POR_MAX_MS      = 110;
    // Counter width covering the longest delay at the default rate
    localparam int unsigned CNT_W           = 32;
    localparam logic        EN_RESET_VAL    = 1'b0;
endpackage : rpes_pkg

//--- rpes_if.sv
// Enable pins and supply status between host sequencer and device
interface rpes_if;
    logic lan_power_enable;
    logic radio_power_enable;
    logic supplies_good;
    modport host (
        output lan_power_enable,
        output radio_power_enable,
        input  supplies_good
    );
    modport device (
        input  lan_power_enable,
        input  radio_power_enable,
        output supplies_good
    );
endinterface : rpes_if

//--- rpes_device.sv
// Device end: regulator control, section resets and power-on reset
module rpes_device #(
    parameter int unsigned MS_CYC = rpes_pkg::MS_CYCLES,
    parameter int unsigned POR_MS = rpes_pkg::POR_MAX_MS
) (
    input  wire logic clk,
    input  wire logic rst_n,
    rpes_if.device    pins,
    input  wire logic core_supply_ok,
    input  wire logic io_supply_ok,
    output logic      regulators_on,
    output logic      lan_reset_n,
    output logic      radio_reset_n,
    output logic      por_done
);
    logic [1:0] lan_sync_ff;
    logic [1:0] radio_sync_ff;
    logic [1:0] core_sync_ff;
    logic [1:0] io_sync_ff;
    logic [31:0] ms_cnt_ff;
    logic [31:0] por_cnt_ff;
    logic [31:0] nxt_ms_cnt;
    logic [31:0] nxt_por_cnt;
    logic        nxt_por_done;
    logic        nxt_regulators_on;
    logic        nxt_lan_reset_n;
    logic        nxt_radio_reset_n;
    logic        lan_en;
    logic        radio_en;
    logic        supplies_ok;

    assign lan_en      = lan_sync_ff[1];
    assign radio_en    = radio_sync_ff[1];
    assign supplies_ok = core_sync_ff[1] & io_sync_ff[1];
    assign pins.supplies_good = supplies_ok;

    always_comb begin
        nxt_ms_cnt   = ms_cnt_ff;
        nxt_por_cnt  = por_cnt_ff;
        nxt_por_done = por_done;
        if (!supplies_ok) begin
            nxt_ms_cnt   = '0;
            nxt_por_cnt  = '0;
            nxt_por_done = 1'b0;
        end else if (!por_done) begin
            // R5 release within limit
            if (ms_cnt_ff >= MS_CYC - 1) begin
                nxt_ms_cnt  = '0;
                nxt_por_cnt = por_cnt_ff + 32'h1;
                if (por_cnt_ff + 32'h1 >= POR_MS) begin
                    nxt_por_done = 1'b1;
                end
            end else begin
                nxt_ms_cnt = ms_cnt_ff + 32'h1;
            end
        end
        // R2 regulators follow OR
        nxt_regulators_on = lan_en | radio_en;
        // R1 lan reset follows enable
        nxt_lan_reset_n   = lan_en & por_done;
        // R3 radio held without its enable
        nxt_radio_reset_n = radio_en & por_done;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lan_sync_ff   <= 2'h0;
            radio_sync_ff <= 2'h0;
            core_sync_ff  <= 2'h0;
            io_sync_ff    <= 2'h0;
            ms_cnt_ff     <= '0;
            por_cnt_ff    <= '0;
            por_done      <= 1'b0;
            regulators_on <= 1'b0;
            lan_reset_n   <= 1'b0;
            radio_reset_n <= 1'b0;
        end else begin
            lan_sync_ff   <= {lan_sync_ff[0], pins.lan_power_enable};
            radio_sync_ff <= {radio_sync_ff[0], pins.radio_power_enable};
            core_sync_ff  <= {core_sync_ff[0], core_supply_ok};
            io_sync_ff    <= {io_sync_ff[0], io_supply_ok};
            ms_cnt_ff     <= nxt_ms_cnt;
            por_cnt_ff    <= nxt_por_cnt;
            por_done      <= nxt_por_done;
            regulators_on <= nxt_regulators_on;
            lan_reset_n   <= nxt_lan_reset_n;
            radio_reset_n <= nxt_radio_reset_n;
        end
    end
endmodule : rpes_device

//--- rpes_host.sv
// Host end: timed sequencing of the two power enables
// Notes on behaviour
// R1 - LAN section reset follows LAN enable
// R2 - Regulators on while either enable high
// R3 - Radio reset while only LAN enabled
// R4 - Wait 10 ms after both low
// R5 - Power-on reset ends within 110 ms
// R6 - Bus access 150 ms after supplies
// R7 - Radio enable rises no later than LAN
// R8 - Radio low only 100 ms after LAN
// R9 - All delays minimum, counters round up
// R10 - Enables low after reset, ms counts
module rpes_host #(
    parameter int unsigned MS_CYC = rpes_pkg::MS_CYCLES,
    parameter int unsigned OFF_MS = rpes_pkg::OFF_GAP_MS,
    parameter int unsigned ACC_MS = rpes_pkg::ACCESS_WAIT_MS,
    parameter int unsigned HOLD_MS = rpes_pkg::RADIO_HOLD_MS
) (
    input  wire logic clk,
    input  wire logic rst_n,
    rpes_if.host      pins,
    input  wire logic want_lan,
    input  wire logic want_radio,
    output logic      access_ok,
    output logic      busy
);
    typedef enum logic [2:0] {
        ST_OFF, ST_GAP, ST_RADIO_ONLY, ST_BOTH_HOLD, ST_BOTH, ST_LAN_ONLY
    } rpes_st_t;

    rpes_st_t    st_ff;
    rpes_st_t    nxt_st;
    logic        lan_ff;
    logic        radio_ff;
    logic        nxt_lan;
    logic        nxt_radio;
    logic [31:0] cyc_ff;
    logic [31:0] nxt_cyc;
    logic [31:0] gap_ms_ff;
    logic [31:0] nxt_gap_ms;
    logic [31:0] hold_ms_ff;
    logic [31:0] nxt_hold_ms;
    logic [31:0] acc_ms_ff;
    logic [31:0] nxt_acc_ms;
    logic        nxt_access_ok;
    logic        nxt_busy;
    logic        ms_tick;
    logic [1:0]  sup_sync_ff;
    logic        sup_ok;

    // Millisecond countdown shared by the gap and hold timers; stops at zero
    function automatic logic [31:0] ms_down(input logic [31:0] cnt, input logic tick);
        logic [31:0] res;
        res = cnt;
        if (tick && cnt != '0) begin
            res = cnt - 32'h1;
        end
        return res;
    endfunction : ms_down

    assign pins.lan_power_enable   = lan_ff;
    assign pins.radio_power_enable = radio_ff;
    assign sup_ok  = sup_sync_ff[1];
    // R10 whole-millisecond tick
    assign ms_tick = (cyc_ff >= MS_CYC - 1);

    // Free-running divider; its tick paces every host timer
    always_comb begin
        nxt_cyc = ms_tick ? '0 : cyc_ff + 32'h1;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cyc_ff <= '0;
        end else begin
            cyc_ff <= nxt_cyc;
        end
    end

    always_comb begin
        nxt_st        = st_ff;
        nxt_lan       = lan_ff;
        nxt_radio     = radio_ff;
        nxt_gap_ms    = gap_ms_ff;
        nxt_hold_ms   = hold_ms_ff;
        nxt_acc_ms    = acc_ms_ff;
        nxt_access_ok = access_ok;
        // R9 counts only on full ms, rounding up
        // Free-running tick phase costs up to one ms, hence the +1 loads
        nxt_gap_ms    = ms_down(gap_ms_ff, ms_tick);
        nxt_hold_ms   = ms_down(hold_ms_ff, ms_tick);
        // R6 access gate after supplies
        if (!sup_ok) begin
            nxt_acc_ms    = ACC_MS + 1;
            nxt_access_ok = 1'b0;
        end else if (acc_ms_ff != '0) begin
            if (ms_tick) begin
                nxt_acc_ms = acc_ms_ff - 32'h1;
            end
        end else begin
            // Access also waits for LAN: the bus sits in that section
            nxt_access_ok = lan_ff;
        end
        unique case (st_ff)
            ST_OFF: begin
                // R7 radio first, LAN with it
                // Radio rises even for a LAN-only request, so order holds
                if (want_radio || want_lan) begin
                    nxt_radio = 1'b1;
                    nxt_lan   = want_lan;
                    nxt_hold_ms = HOLD_MS + 1;
                    nxt_st    = want_lan ? ST_BOTH_HOLD : ST_RADIO_ONLY;
                end
            end
            ST_GAP: begin
                // R4 discharge gap after both low
                if (gap_ms_ff == '0) begin
                    nxt_st = ST_OFF;
                end
            end
            ST_RADIO_ONLY: begin
                if (want_lan) begin
                    nxt_lan     = 1'b1;
                    nxt_hold_ms = HOLD_MS + 1;
                    nxt_st      = ST_BOTH_HOLD;
                end else if (!want_radio) begin
                    nxt_radio  = 1'b0;
                    nxt_gap_ms = OFF_MS + 1;
                    nxt_st     = ST_GAP;
                end
            end
            ST_BOTH_HOLD: begin
                // R8 radio kept high 100 ms
                if (hold_ms_ff == '0) begin
                    nxt_st = ST_BOTH;
                end
            end
            ST_BOTH: begin
                if (!want_lan && !want_radio) begin
                    nxt_lan    = 1'b0;
                    nxt_radio  = 1'b0;
                    nxt_gap_ms = OFF_MS + 1;
                    nxt_st     = ST_GAP;
                end else if (!want_lan) begin
                    nxt_lan = 1'b0;
                    nxt_st  = ST_RADIO_ONLY;
                end else if (!want_radio) begin
                    nxt_radio = 1'b0;
                    nxt_st    = ST_LAN_ONLY;
                end
            end
            ST_LAN_ONLY: begin
                if (!want_lan) begin
                    nxt_lan    = 1'b0;
                    nxt_gap_ms = OFF_MS + 1;
                    nxt_st     = ST_GAP;
                end else if (want_radio) begin
                    // Radio may rise any time while LAN is up
                    nxt_radio = 1'b1;
                    nxt_st    = ST_BOTH;
                end
            end
            default: begin
                // Illegal codes fall back to off with enables kept
                nxt_st = ST_OFF;
            end
        endcase
        if (!nxt_lan) begin
            nxt_access_ok = 1'b0;
        end
        // Busy marks windows in which requests are ignored
        nxt_busy = (nxt_st == ST_GAP) || (nxt_st == ST_BOTH_HOLD);
    end

    always_ff @(posedge clk) begin
        // R10 enables low after reset
        if (!rst_n) begin
            st_ff       <= ST_OFF;
            lan_ff      <= rpes_pkg::EN_RESET_VAL;
            radio_ff    <= rpes_pkg::EN_RESET_VAL;
            gap_ms_ff   <= '0;
            hold_ms_ff  <= '0;
            acc_ms_ff   <= '0;
            access_ok   <= 1'b0;
            busy        <= 1'b0;
        end else begin
            st_ff       <= nxt_st;
            lan_ff      <= nxt_lan;
            radio_ff    <= nxt_radio;
            gap_ms_ff   <= nxt_gap_ms;
            hold_ms_ff  <= nxt_hold_ms;
            acc_ms_ff   <= nxt_acc_ms;
            access_ok   <= nxt_access_ok;
            busy        <= nxt_busy;
        end
    end

    // Status comes over a pin, so it passes two flops first
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sup_sync_ff <= 2'h0;
        end else begin
            sup_sync_ff <= {sup_sync_ff[0], pins.supplies_good};
        end
    end
endmodule : rpes_host

//--- rpes_checker.sv
// Checker on the enable wires between host sequencer and device
module rpes_checker #(
    parameter int unsigned MS_CYC = rpes_pkg::MS_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic lan_power_enable,
    input wire logic radio_power_enable,
    input wire logic supplies_good
);
    localparam int unsigned OFF_CYC  = rpes_pkg::OFF_GAP_MS * MS_CYC;
    localparam int unsigned HOLD_CYC = rpes_pkg::RADIO_HOLD_MS * MS_CYC;
    logic [31:0] off_cnt_ff;
    logic [31:0] nxt_off_cnt;
    logic [31:0] lan_cnt_ff;
    logic [31:0] nxt_lan_cnt;
    logic        any_en;
    always_comb begin
        any_en      = lan_power_enable | radio_power_enable;
        nxt_off_cnt = any_en ? 32'h0 : off_cnt_ff + {31'h0, off_cnt_ff < 32'hffffffff};
        nxt_lan_cnt = lan_power_enable ? lan_cnt_ff + {31'h0, lan_cnt_ff < 32'hffffffff} : 32'h0;
    end
    // Idle count starts saturated: no gap is owed right after reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            off_cnt_ff <= 32'hffffffff;
            lan_cnt_ff <= 32'h0;
        end else begin
            off_cnt_ff <= nxt_off_cnt;
            lan_cnt_ff <= nxt_lan_cnt;
        end
    end
    chk_reset_enables_low: assert property (@(posedge clk)
        !rst_n |=> !lan_power_enable && !radio_power_enable)
        else $error("enables not low after reset");
    chk_radio_before_lan: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(lan_power_enable) |-> radio_power_enable)
        else $error("lan enable rose without radio enable");
    chk_radio_hold_time: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(radio_power_enable) && lan_power_enable |-> lan_cnt_ff >= HOLD_CYC)
        else $error("radio enable dropped too soon after lan enable");
    chk_off_gap_time: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(any_en) |-> off_cnt_ff >= OFF_CYC)
        else $error("enable raised within discharge gap");
    chk_radio_kept_up: assert property (@(posedge clk) disable iff (!rst_n)
        lan_power_enable && lan_cnt_ff < HOLD_CYC |=> radio_power_enable)
        else $error("radio enable low within hold after lan enable");
    chk_gap_kept_low: assert property (@(posedge clk) disable iff (!rst_n)
        !any_en && off_cnt_ff < OFF_CYC |=> !any_en)
        else $error("enable raised before discharge gap ended");
    cov_radio_drop: cover property (@(posedge clk) disable iff (!rst_n)
        $fell(radio_power_enable) && lan_power_enable);
endmodule : rpes_checker

//--- radio_power_enable_sequencer_test.sv
// Self-checking bench: host and device ends joined by the enable interface
module radio_power_enable_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    // Short millisecond keeps the run small
    localparam int unsigned MS = 10;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic core_ok = 1'b0;
    logic io_ok = 1'b0;
    logic want_lan = 1'b0;
    logic want_radio = 1'b0;
    logic access_ok, busy, regulators_on, lan_reset_n, radio_reset_n, por_done;
    int   n_errors = 0;
    int   n_compared = 0;
    int   i;
    // Rows: wants, then lan, radio, regulators, lan reset, radio reset, access
    logic [7:0] rows [7] = '{8'had, 8'h00, 8'h5a, 8'hff, 8'h00, 8'had, 8'h00};
    rpes_if u_rpes_if ();
    rpes_host #(.MS_CYC(MS)) u_rpes_host (.clk(clk), .rst_n(rst_n), .pins(u_rpes_if),
        .want_lan(want_lan), .want_radio(want_radio), .access_ok(access_ok), .busy(busy));
    rpes_device #(.MS_CYC(MS)) u_rpes_device (.clk(clk), .rst_n(rst_n), .pins(u_rpes_if),
        .core_supply_ok(core_ok), .io_supply_ok(io_ok), .regulators_on(regulators_on),
        .lan_reset_n(lan_reset_n), .radio_reset_n(radio_reset_n), .por_done(por_done));
    rpes_checker #(.MS_CYC(MS)) u_rpes_checker (.clk(clk), .rst_n(rst_n),
        .lan_power_enable(u_rpes_if.lan_power_enable),
        .radio_power_enable(u_rpes_if.radio_power_enable),
        .supplies_good(u_rpes_if.supplies_good));
    always #20 clk = ~clk;
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick
    task automatic check(input string name, input logic [5:0] seen, input logic [5:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    function automatic logic [5:0] obs();
        return {u_rpes_if.lan_power_enable, u_rpes_if.radio_power_enable, regulators_on,
                lan_reset_n, radio_reset_n, access_ok};
    endfunction : obs
    task automatic settle();
        int k;
        tick(2);
        for (k = 0; k < 3000 && busy !== 1'b0; k++) tick(1);
        tick(6);
    endtask : settle
    task automatic stop_test();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        stop_test();
    end
    initial begin
        tick(2);
        rst_n = 1'b1;
        core_ok = 1'b1;
        {want_lan, want_radio} = 2'b11;
        tick(20);
        // Late io supply: the reset hold counts from both supplies good
        io_ok = 1'b1;
        check("early", obs(), 6'h38);
        for (i = 0; i < MS * 110 + 10 && por_done !== 1'b1; i++) tick(1);
        check("por", {5'h0, por_done}, 6'h01);
        check("access early", {5'h0, access_ok}, 6'h00);
        for (i = 0; i < MS * 160 && access_ok !== 1'b1; i++) tick(1);
        check("access", {5'h0, access_ok}, 6'h01);
        $display("test power-on done");
        foreach (rows[r]) begin
            {want_lan, want_radio} = rows[r][7:6];
            settle();
            check("row", obs(), rows[r][5:0]);
        end
        $display("test rows done");
        {want_lan, want_radio} = 2'b11;
        tick(3);
        {want_lan, want_radio} = 2'b00;
        tick(10);
        check("hold", obs(), 6'h3f);
        check("hold busy", {5'h0, busy}, 6'h01);
        for (i = 0; i < 3000 && busy !== 1'b0; i++) tick(1);
        tick(3);
        {want_lan, want_radio} = 2'b11;
        tick(20);
        check("gap", obs(), 6'h00);
        check("gap busy", {5'h0, busy}, 6'h01);
        settle();
        check("after gap", obs(), 6'h3f);
        $display("test refusals done");
        rst_n = 1'b0;
        tick(2);
        check("reset", obs(), 6'h00);
        rst_n = 1'b1;
        $display("test reset done");
        stop_test();
    end
endmodule : radio_power_enable_sequencer_test
